// [hdl/fcp_pkg.sv]
package fcp_pkg;
  localparam int CH_NUM = 4;
  localparam int PRESCALE_W = 7;

  // Register offsets, one byte each
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h40;
  localparam logic [7:0] ADDR_POL_CTRL = 8'h41;
  localparam logic [7:0] ADDR_ENABLE = 8'h42;
  localparam logic [7:0] ADDR_PRESCALE = 8'h43;
  localparam logic [7:0] ADDR_SCALE0 = 8'h44;
  localparam logic [7:0] ADDR_SCNT0 = 8'h45;
  localparam logic [7:0] ADDR_SCALE1 = 8'h46;
  localparam logic [7:0] ADDR_SCNT1 = 8'h47;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h48;
  localparam logic [7:0] ADDR_PER_BASE = 8'h4C;
  localparam logic [7:0] ADDR_DUTY_BASE = 8'h50;
  localparam logic [7:0] ADDR_ALIGN = 8'h54;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h56;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h57;
  localparam logic [7:0] GROUP_SPAN = 8'h04;

  // Field positions
  localparam int JOIN_HI_BIT = 7;
  localparam int JOIN_LO_BIT = 6;
  localparam int PRE_A_LSB = 3;
  localparam int PRE_B_LSB = 0;
  localparam int SEL_LSB = 4;
  localparam int POL_LSB = 0;
  localparam int CENTER_BIT = 0;
  localparam logic [7:0] ENABLE_MASK = 8'h0F;
  localparam logic [7:0] ALIGN_MASK = 8'h01;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] PER_RESET = 8'hFF;
  localparam logic [7:0] DUTY_RESET = 8'hFF;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 7'h00;
endpackage : fcp_pkg

// [hdl/fcp_pwm.sv]
`timescale 1ns/1ns
module fcp_pwm
  import fcp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOeN
);

  logic [7:0] clkCtrl_ff;
  logic [7:0] polCtrl_ff;
  logic [7:0] enable_ff;
  logic [7:0] align_ff;
  logic [7:0] portData_ff;
  logic [7:0] portDir_ff;
  logic [PRESCALE_W-1:0] prescale_ff;
  logic [7:0] scale_ff [2];
  logic [7:0] scnt_ff [2];
  logic [1:0] half_ff;
  logic [7:0] cnt_ff [CH_NUM];
  logic [7:0] perBuf_ff [CH_NUM];
  logic [7:0] perAct_ff [CH_NUM];
  logic [7:0] dutyBuf_ff [CH_NUM];
  logic [7:0] dutyAct_ff [CH_NUM];
  logic [3:0] dirDown_ff;
  logic [3:0] pinSync1_ff;
  logic [3:0] pinSync2_ff;
  logic [3:0] pinOut_ff;
  logic [3:0] pinOeN_ff;
  logic [7:0] regRdata_ff;

  logic [1:0] baseTick;
  logic [1:0] scaleTick;
  logic [3:0] chTick;
  logic [3:0] joined;
  logic [3:0] laneEn;
  logic [3:0] laneLatch;
  logic [3:0] cmpOut;
  logic [3:0] drive;
  logic [3:0] cntClr;
  logic [3:0] perWr;
  logic [3:0] dutyWr;
  logic [7:0] nxt_cnt [CH_NUM];
  logic [3:0] nxt_dir;
  logic [7:0] rdVal;

  function automatic logic [PRESCALE_W-1:0] divMask(input logic [2:0] code);
    return PRESCALE_W'((8'h01 << code) - 8'h01);
  endfunction : divMask

  function automatic logic hitGroup(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + GROUP_SPAN);
  endfunction : hitGroup

  // Returns {rollover, direction down, next count}
  function automatic logic [17:0] stepCnt(input logic [15:0] c, input logic [15:0] p,
                                          input logic d, input logic ctr);
    logic [15:0] nc;
    logic nd;
    logic roll;
    nc = c + 16'h0001;
    nd = d;
    roll = 1'b0;
    if (!ctr) begin
      nd = 1'b0;
      if (c >= p) begin
        nc = 16'h0000;
        roll = 1'b1;
      end
    end else if (d) begin
      nc = (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
      if (c <= 16'h0001) begin
        nd = 1'b0;
        roll = 1'b1;
      end
    end else if (c >= p) begin
      nd = 1'b1;
      nc = (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
    end
    return {roll, nd, nc};
  endfunction : stepCnt

  // Clock sources
  assign baseTick[0] = (prescale_ff & divMask(clkCtrl_ff[PRE_A_LSB +: 3])) ==
                       divMask(clkCtrl_ff[PRE_A_LSB +: 3]);
  assign baseTick[1] = (prescale_ff & divMask(clkCtrl_ff[PRE_B_LSB +: 3])) ==
                       divMask(clkCtrl_ff[PRE_B_LSB +: 3]);

  // Free running even when all channels are off; costs power, keeps phase simple
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prescale_ff <= PRESCALE_RESET;
    end else begin
      prescale_ff <= prescale_ff + 7'h01;
    end
  end

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      scaleTick[s] = baseTick[s] && (scnt_ff[s] == 8'h00) && half_ff[s];
    end
    for (int c = 0; c < CH_NUM; c++) begin
      chTick[c] = polCtrl_ff[SEL_LSB + c] ? scaleTick[c / 2] : baseTick[c / 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int s = 0; s < 2; s++) begin
        scale_ff[s] <= CTRL_RESET;
        scnt_ff[s] <= CTRL_RESET;
      end
      half_ff <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (regWr && regAddr == (s == 0 ? ADDR_SCALE0 : ADDR_SCALE1)) begin
          scale_ff[s] <= regWdata;
          scnt_ff[s] <= regWdata;
          half_ff[s] <= 1'b0;
        end else if (baseTick[s]) begin
          if (scnt_ff[s] == 8'h00) begin
            scnt_ff[s] <= scale_ff[s];
            half_ff[s] <= ~half_ff[s];
          end else begin
            scnt_ff[s] <= scnt_ff[s] - 8'h01;
          end
        end
      end
    end
  end

  assign joined = {{2{clkCtrl_ff[JOIN_HI_BIT]}}, {2{clkCtrl_ff[JOIN_LO_BIT]}}};

  // Both bytes of a joined pair compute the same 16-bit lane and keep their own byte
  always_comb begin
    int hi;
    int lo;
    int own;
    logic [15:0] cc;
    logic [15:0] pp;
    logic [15:0] dd;
    logic [17:0] st;
    logic tick;
    hi = 0;
    lo = 0;
    own = 0;
    cc = 16'h0000;
    pp = 16'h0000;
    dd = 16'h0000;
    st = 18'h00000;
    tick = 1'b0;
    for (int c = 0; c < CH_NUM; c++) begin
      hi = c - (c % 2);
      lo = hi + 1;
      own = joined[c] ? hi : c;
      if (joined[c]) begin
        cc = {cnt_ff[hi], cnt_ff[lo]};
        pp = {perAct_ff[hi], perAct_ff[lo]};
        dd = {dutyAct_ff[hi], dutyAct_ff[lo]};
        tick = chTick[lo];
      end else begin
        cc = {8'h00, cnt_ff[c]};
        pp = {8'h00, perAct_ff[c]};
        dd = {8'h00, dutyAct_ff[c]};
        tick = chTick[c];
      end
      st = stepCnt(cc, pp, dirDown_ff[own], align_ff[CENTER_BIT]);
      laneEn[c] = enable_ff[own];
      nxt_cnt[c] = cnt_ff[c];
      nxt_dir[c] = dirDown_ff[c];
      if (laneEn[c] && tick) begin
        nxt_cnt[c] = (joined[c] && c == hi) ? st[15:8] : st[7:0];
        nxt_dir[c] = st[16];
      end
      laneLatch[c] = !laneEn[c] || (tick && st[17]);
      // Duty zero or above period gives the two constant extremes
      cmpOut[c] = polCtrl_ff[POL_LSB + own] ? (cc < dd) : (cc >= dd);
      drive[c] = laneEn[c] && !(joined[c] && c == lo);
      cntClr[c] = regWr && hitGroup(regAddr, ADDR_CNT_BASE) &&
                  (regAddr[1:0] == 2'(c) || (joined[c] && regAddr[1] == 1'(c / 2)));
      perWr[c] = regWr && hitGroup(regAddr, ADDR_PER_BASE) && regAddr[1:0] == 2'(c);
      dutyWr[c] = regWr && hitGroup(regAddr, ADDR_DUTY_BASE) && regAddr[1:0] == 2'(c);
    end
  end

  // Control registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clkCtrl_ff <= CTRL_RESET;
      polCtrl_ff <= CTRL_RESET;
      enable_ff <= CTRL_RESET;
      align_ff <= CTRL_RESET;
      portData_ff <= CTRL_RESET;
      portDir_ff <= CTRL_RESET;
    end else if (regWr) begin
      if (regAddr == ADDR_CLK_CTRL) begin
        clkCtrl_ff <= regWdata;
      end else if (regAddr == ADDR_POL_CTRL) begin
        polCtrl_ff <= regWdata;
      end else if (regAddr == ADDR_ENABLE) begin
        enable_ff <= regWdata & ENABLE_MASK;
      end else if (regAddr == ADDR_ALIGN) begin
        align_ff <= regWdata & ALIGN_MASK;
      end else if (regAddr == ADDR_PORT_DATA) begin
        portData_ff <= regWdata & ENABLE_MASK;
      end else if (regAddr == ADDR_PORT_DIR) begin
        portDir_ff <= regWdata & ENABLE_MASK;
      end
    end
  end

  // Counters hold while disabled; software clears them before re-enabling
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < CH_NUM; c++) begin
        cnt_ff[c] <= CNT_RESET;
      end
      dirDown_ff <= 4'h0;
    end else begin
      for (int c = 0; c < CH_NUM; c++) begin
        if (cntClr[c]) begin
          cnt_ff[c] <= CNT_RESET;
          dirDown_ff[c] <= 1'b0;
        end else begin
          cnt_ff[c] <= nxt_cnt[c];
          dirDown_ff[c] <= nxt_dir[c];
        end
      end
    end
  end

  // Double-buffered period and duty
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < CH_NUM; c++) begin
        perBuf_ff[c] <= PER_RESET;
        perAct_ff[c] <= PER_RESET;
        dutyBuf_ff[c] <= DUTY_RESET;
        dutyAct_ff[c] <= DUTY_RESET;
      end
    end else begin
      for (int c = 0; c < CH_NUM; c++) begin
        if (perWr[c]) begin
          perBuf_ff[c] <= regWdata;
        end
        if (perWr[c] && !laneEn[c]) begin
          perAct_ff[c] <= regWdata;
        end else if (laneLatch[c] || cntClr[c]) begin
          perAct_ff[c] <= perBuf_ff[c];
        end
        if (dutyWr[c]) begin
          dutyBuf_ff[c] <= regWdata;
        end
        if (dutyWr[c] && !laneEn[c]) begin
          dutyAct_ff[c] <= regWdata;
        end else if (laneLatch[c] || cntClr[c]) begin
          dutyAct_ff[c] <= dutyBuf_ff[c];
        end
      end
    end
  end

  // Pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinSync1_ff <= 4'h0;
      pinSync2_ff <= 4'h0;
      pinOut_ff <= 4'h0;
      pinOeN_ff <= 4'hF;
    end else begin
      pinSync1_ff <= pinIn;
      pinSync2_ff <= pinSync1_ff;
      for (int c = 0; c < CH_NUM; c++) begin
        pinOut_ff[c] <= drive[c] ? cmpOut[c] : portData_ff[c];
        pinOeN_ff[c] <= !(drive[c] || portDir_ff[c]);
      end
    end
  end

  assign pinOut = pinOut_ff;
  assign pinOeN = pinOeN_ff;

  // Read path; unmapped offsets read zero
  always_comb begin
    rdVal = 8'h00;
    if (regAddr == ADDR_CLK_CTRL) begin
      rdVal = clkCtrl_ff;
    end else if (regAddr == ADDR_POL_CTRL) begin
      rdVal = polCtrl_ff;
    end else if (regAddr == ADDR_ENABLE) begin
      rdVal = enable_ff;
    end else if (regAddr == ADDR_PRESCALE) begin
      rdVal = {1'b0, prescale_ff};
    end else if (regAddr == ADDR_SCALE0) begin
      rdVal = scale_ff[0];
    end else if (regAddr == ADDR_SCNT0) begin
      rdVal = scnt_ff[0];
    end else if (regAddr == ADDR_SCALE1) begin
      rdVal = scale_ff[1];
    end else if (regAddr == ADDR_SCNT1) begin
      rdVal = scnt_ff[1];
    end else if (hitGroup(regAddr, ADDR_CNT_BASE)) begin
      rdVal = cnt_ff[regAddr[1:0]];
    end else if (hitGroup(regAddr, ADDR_PER_BASE)) begin
      rdVal = perBuf_ff[regAddr[1:0]];
    end else if (hitGroup(regAddr, ADDR_DUTY_BASE)) begin
      rdVal = dutyBuf_ff[regAddr[1:0]];
    end else if (regAddr == ADDR_ALIGN) begin
      rdVal = align_ff;
    end else if (regAddr == ADDR_PORT_DATA) begin
      rdVal = {4'h0, (portDir_ff[3:0] & portData_ff[3:0]) | (~portDir_ff[3:0] & pinSync2_ff)};
    end else if (regAddr == ADDR_PORT_DIR) begin
      rdVal = portDir_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata_ff <= 8'h00;
    end else begin
      regRdata_ff <= regRd ? rdVal : 8'h00;
    end
  end

  assign regRdata = regRdata_ff;

  a_cnt_write_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    regWr && regAddr == ADDR_CNT_BASE |=> cnt_ff[0] == 8'h00 &&
    perAct_ff[0] == $past(perBuf_ff[0]))
    else $error("counter write did not clear and latch");
  a_idle_write_direct: assert property (@(posedge ref_clk) disable iff (!rstn)
    regWr && regAddr == ADDR_PER_BASE && !laneEn[0] |=> perAct_ff[0] == $past(regWdata))
    else $error("idle period write missed active value");
  a_buffer_held: assert property (@(posedge ref_clk) disable iff (!rstn)
    laneEn[0] && !laneLatch[0] && !cntClr[0] |=> $stable(perAct_ff[0]) &&
    $stable(dutyAct_ff[0]))
    else $error("active period or duty changed mid period");

  a_enable_drives: assert property (@(posedge ref_clk) disable iff (!rstn)
    laneEn[1] && !joined[1] && !regWr |=> !pinOeN[1] && $stable(portDir_ff[1]))
    else $error("enabled channel pin not driven");
  a_join_pin_free: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkCtrl_ff[JOIN_HI_BIT] && !portDir_ff[3] |=> pinOeN[3])
    else $error("joined low channel still drives its pin");
  a_join_pin_gpio: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkCtrl_ff[JOIN_LO_BIT] |=> pinOut[1] == $past(portData_ff[1]))
    else $error("joined low channel pin not general purpose");

  a_prescale_half: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkCtrl_ff[PRE_A_LSB +: 3] == 3'h1 && baseTick[0] && !regWr |=> !baseTick[0])
    else $error("clock A divide by two ticked twice in a row");
  a_scaled_halves: assert property (@(posedge ref_clk) disable iff (!rstn)
    scaleTick[0] |=> !half_ff[0] && scnt_ff[0] == scale_ff[0])
    else $error("scaled clock S0 not halved");

  a_polarity_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    laneEn[0] && !joined[0] && !polCtrl_ff[POL_LSB] && cnt_ff[0] < dutyAct_ff[0]
    |=> !pinOut[0])
    else $error("polarity zero output high before duty");

  a_ctrl_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    regWr && regAddr == ADDR_CLK_CTRL ##1 !regWr ##1 regRd && regAddr == ADDR_CLK_CTRL
    |=> regRdata == $past(regWdata, 3))
    else $error("clock control readback mismatch");

endmodule : fcp_pwm

// [test/fcp_pin_model.sv]
`timescale 1ns/1ns
module fcp_pin_model (
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOeN,
  input wire logic [3:0] extVal,
  input wire logic [3:0] extEn,
  output logic [3:0] pinIn
);
  // Pull-up on every line; outside drivers back off while the block drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pinOeN[i] == 1'b0) begin
        pinIn[i] = pinOut[i];
      end else if (extEn[i] == 1'b1) begin
        pinIn[i] = extVal[i];
      end else begin
        pinIn[i] = 1'b1;
      end
    end
  end
endmodule : fcp_pin_model

// [test/tb.sv]
`timescale 1ns/1ns
module tb;
  import fcp_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic [3:0] pinIn;
  logic [3:0] pinOut;
  logic [3:0] pinOeN;
  logic [3:0] extVal = 4'h0;
  logic [3:0] extEn = 4'h0;
  int err_count = 0;
  int checked = 0;
  logic [7:0] rv;
  int hi;
  int ed;
  logic [7:0] rstA [9] = '{8'h40, 8'h41, 8'h42, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h55, 8'h57};
  logic [7:0] rstV [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

  always #5 ref_clk = ~ref_clk;

  fcp_pwm u_dut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOeN(pinOeN)
  );

  fcp_pin_model u_pins (
    .pinOut(pinOut),
    .pinOeN(pinOeN),
    .extVal(extVal),
    .extEn(extEn),
    .pinIn(pinIn)
  );

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // Counter cleared last so a stale count cannot truncate the first period
  task automatic chan(input int ch, input logic [7:0] per, input logic [7:0] duty);
    wr(8'(ADDR_PER_BASE + ch), per);
    wr(8'(ADDR_DUTY_BASE + ch), duty);
    wr(8'(ADDR_CNT_BASE + ch), 8'h00);
  endtask : chan

  // Window must be a whole number of periods so counts do not depend on phase
  task automatic meas(input int ch, input int n, output int high, output int rise);
    logic prev;
    high = 0;
    rise = 0;
    @(posedge ref_clk);
    #1 prev = pinOut[ch];
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (pinOut[ch] === 1'b1) high++;
      if (pinOut[ch] === 1'b1 && prev === 1'b0) rise++;
      prev = pinOut[ch];
    end
  endtask : meas

  initial begin
    #500000;
    err_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(rstA[i], rv);
      chk(16'(rv), 16'(rstV[i]));
    end
    wr(ADDR_CLK_CTRL, 8'hA5);
    rd(ADDR_CLK_CTRL, rv);
    chk(16'(rv), 16'h00A5);
    wr(ADDR_POL_CTRL, 8'h5A);
    rd(ADDR_POL_CTRL, rv);
    chk(16'(rv), 16'h005A);
    wr(ADDR_CLK_CTRL, 8'h00);
    wr(ADDR_POL_CTRL, 8'h00);
    extEn <= 4'hF;
    extVal <= 4'h9;
    repeat (4) @(posedge ref_clk);
    rd(ADDR_PORT_DATA, rv);
    chk(16'(rv), 16'h0009);
    wr(ADDR_PORT_DIR, 8'h03);
    wr(ADDR_PORT_DATA, 8'h0A);
    repeat (4) @(posedge ref_clk);
    chk({12'h000, pinOeN}, 16'h000C);
    chk({14'h0000, pinOut[1:0]}, 16'h0002);
    rd(ADDR_PORT_DATA, rv);
    chk(16'(rv), 16'h000A);
    wr(ADDR_PORT_DIR, 8'h00);
    chan(0, 8'h03, 8'h01);
    wr(ADDR_ENABLE, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk({15'h0000, pinOeN[0]}, 16'h0000);
    rd(ADDR_PORT_DIR, rv);
    chk(16'(rv), 16'h0000);
    meas(0, 40, hi, ed);
    chk(16'(hi), 16'd30);
    wr(ADDR_POL_CTRL, 8'h01);
    repeat (8) @(posedge ref_clk);
    meas(0, 40, hi, ed);
    chk(16'(hi), 16'd10);
    wr(ADDR_POL_CTRL, 8'h00);
    wr(ADDR_DUTY_BASE, 8'h00);
    repeat (8) @(posedge ref_clk);
    meas(0, 40, hi, ed);
    chk(16'(hi), 16'd40);
    wr(ADDR_DUTY_BASE, 8'h04);
    repeat (8) @(posedge ref_clk);
    meas(0, 40, hi, ed);
    chk(16'(hi), 16'd0);
    wr(ADDR_DUTY_BASE, 8'h02);
    wr(ADDR_ALIGN, 8'h01);
    repeat (12) @(posedge ref_clk);
    meas(0, 48, hi, ed);
    chk(16'(ed), 16'd8);
    wr(ADDR_ALIGN, 8'h00);
    wr(ADDR_ENABLE, 8'h00);
    // Slowest clock A so the count sits at zero while the duty write waits
    wr(ADDR_CLK_CTRL, 8'h38);
    chan(0, 8'h03, 8'h03);
    wr(ADDR_ENABLE, 8'h01);
    wr(ADDR_DUTY_BASE, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk({15'h0000, pinOut[0]}, 16'h0000);
    wr(ADDR_CNT_BASE, 8'h00);
    repeat (4) @(posedge ref_clk);
    chk({15'h0000, pinOut[0]}, 16'h0001);
    rd(ADDR_CNT_BASE, rv);
    chk({15'h0000, rv <= 8'h01}, 16'h0001);
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_DUTY_BASE, 8'h02);
    for (int n = 0; n < 8; n++) begin
      wr(ADDR_CLK_CTRL, 8'(n << 3));
      wr(ADDR_CNT_BASE, 8'h00);
      wr(ADDR_ENABLE, 8'h01);
      repeat (8 << n) @(posedge ref_clk);
      meas(0, 32 << n, hi, ed);
      chk(16'(ed), 16'd8);
      wr(ADDR_ENABLE, 8'h00);
    end
    // Clock select only changed while the channel is off
    wr(ADDR_CLK_CTRL, 8'h00);
    wr(ADDR_SCALE0, 8'h01);
    wr(ADDR_POL_CTRL, 8'h10);
    wr(ADDR_CNT_BASE, 8'h00);
    wr(ADDR_ENABLE, 8'h01);
    repeat (32) @(posedge ref_clk);
    meas(0, 128, hi, ed);
    chk(16'(ed), 16'd8);
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_POL_CTRL, 8'h00);
    wr(ADDR_CLK_CTRL, 8'h01);
    chan(2, 8'h03, 8'h02);
    wr(ADDR_ENABLE, 8'h04);
    repeat (16) @(posedge ref_clk);
    meas(2, 64, hi, ed);
    chk(16'(ed), 16'd8);
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_SCALE1, 8'h00);
    wr(ADDR_POL_CTRL, 8'h40);
    wr(8'(ADDR_CNT_BASE + 2), 8'h00);
    wr(ADDR_ENABLE, 8'h04);
    repeat (32) @(posedge ref_clk);
    meas(2, 64, hi, ed);
    chk(16'(ed), 16'd4);
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_POL_CTRL, 8'h00);
    wr(ADDR_CLK_CTRL, 8'h00);
    for (int c = 0; c < 4; c++) chan(c, 8'(c + 1), 8'h01);
    wr(ADDR_ENABLE, 8'h0F);
    for (int c = 0; c < 4; c++) begin
      meas(c, 120, hi, ed);
      chk(16'(ed), 16'(120 / (c + 2)));
    end
    wr(ADDR_ENABLE, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CLK_CTRL, 8'(1 << (6 + p)));
      wr(8'(ADDR_PER_BASE + 2 * p), 8'h01);
      wr(8'(ADDR_PER_BASE + 2 * p + 1), 8'h00);
      wr(8'(ADDR_DUTY_BASE + 2 * p), 8'h00);
      wr(8'(ADDR_DUTY_BASE + 2 * p + 1), 8'h80);
      wr(8'(ADDR_CNT_BASE + 2 * p), 8'h00);
      wr(ADDR_ENABLE, 8'(3 << (2 * p)));
      repeat (20) @(posedge ref_clk);
      chk({15'h0000, pinOeN[2 * p + 1]}, 16'h0001);
      meas(2 * p, 514, hi, ed);
      chk(16'(hi), 16'd258);
      wr(ADDR_ENABLE, 8'h00);
    end
    complete_run();
  end
endmodule : tb
